/* accel_pkg.sv */
// Types shared by the register bank and the output composer.
// Assumes accel_regs.svh for the numeric constants.
package accel_pkg;
  typedef logic [7:0]         byte_type;
  typedef logic signed [15:0] sample_type;
  typedef enum logic [1:0] {
    RANGE_LOWEST = 2'h0,
    RANGE_SECOND = 2'h1,
    RANGE_THIRD  = 2'h2,
    RANGE_TOP    = 2'h3
  } range_type;
endpackage

/* accel_register_bank.sv */
// Register bank of the acceleration sensor with output sample bytes.
// Assumes the serial front end presents one-cycle read and write strobes
// with a byte address, and samples come from logic on the same clock.
`timescale 1ns/100ps
`include "accel_regs.svh"
module accel_register_bank
  import accel_pkg::*;
#(
  parameter byte_type   DEVICE_CODE = 8'h3C, // Arbitrary identification value
  parameter sample_type DEFL_X      = 16'sh012C,
  parameter sample_type DEFL_Z      = 16'sh01F4
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire byte_type   reg_addr,
  input  wire byte_type   reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output byte_type        reg_rdata,
  output logic            reg_rvalid,
  input  wire sample_type sample_x,
  input  wire sample_type sample_y,
  input  wire sample_type sample_z,
  input  wire logic       sample_valid,
  output logic            self_check_en,
  output logic            low_power_en,
  output logic            measure_en,
  output logic [3:0]      data_rate
);

  // True for every address software may write
  function automatic logic is_writable(input byte_type a);
    return (a >= `ADDR_X_OFFSET_TRIM && a <= `ADDR_Z_OFFSET_TRIM) ||
           (a >= `ADDR_MOTION_THRESHOLD && a <= `ADDR_MOTION_AXIS_CTL) ||
           (a >= `ADDR_RATE_POWER_SAVING_CONTROL && a <= `ADDR_EVENT_PIN_ROUTE) ||
           (a == `ADDR_OUTPUT_FORMAT) || (a == `ADDR_BUFFER_CONTROL);
  endfunction

  // True for the six axis output bytes
  function automatic logic is_output(input byte_type a);
    return (a >= `ADDR_X_OUTPUT_LOW) && (a <= `ADDR_Z_OUTPUT_HIGH);
  endfunction

  byte_type   x_offset_trim_reg;
  byte_type   y_offset_trim_reg;
  byte_type   z_offset_trim_reg;
  byte_type   motion_threshold_reg;
  byte_type   stillness_threshold_reg;
  byte_type   stillness_time_reg;
  byte_type   motion_axis_control_reg;
  byte_type   rate_power_control_reg;
  byte_type   power_saving_control_reg;
  byte_type   event_enable_reg;
  byte_type   event_pin_routing_reg;
  byte_type   output_format_control_reg;
  byte_type   buffer_control_reg;
  sample_type x_out_reg;
  sample_type y_out_reg;
  sample_type z_out_reg;
  logic       data_ready_reg;
  byte_type   rdata_next;
  logic       wr_ok;

  sample_if sif ();

  assign wr_ok = reg_wr && is_writable(reg_addr);

  // Software-writable configuration; other addresses are ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      x_offset_trim_reg         <= `RST_ZERO;
      y_offset_trim_reg         <= `RST_ZERO;
      z_offset_trim_reg         <= `RST_ZERO;
      motion_threshold_reg      <= `RST_ZERO;
      stillness_threshold_reg   <= `RST_ZERO;
      stillness_time_reg        <= `RST_ZERO;
      motion_axis_control_reg   <= `RST_ZERO;
      rate_power_control_reg    <= `RST_RATE_POWER;
      power_saving_control_reg  <= `RST_ZERO;
      event_enable_reg          <= `RST_ZERO;
      event_pin_routing_reg     <= `RST_ZERO;
      output_format_control_reg <= `RST_ZERO;
      buffer_control_reg        <= `RST_ZERO;
    end else if (wr_ok) begin
      if (reg_addr == `ADDR_X_OFFSET_TRIM) begin
        x_offset_trim_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_Y_OFFSET_TRIM) begin
        y_offset_trim_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_Z_OFFSET_TRIM) begin
        z_offset_trim_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_MOTION_THRESHOLD) begin
        motion_threshold_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_STILL_THRESHOLD) begin
        stillness_threshold_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_STILL_TIME) begin
        stillness_time_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_MOTION_AXIS_CTL) begin
        motion_axis_control_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_RATE_POWER_SAVING_CONTROL) begin
        rate_power_control_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_POWER_SAVING_CTL) begin
        power_saving_control_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_EVENT_ENABLE) begin
        event_enable_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_EVENT_PIN_ROUTE) begin
        event_pin_routing_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_OUTPUT_FORMAT) begin
        output_format_control_reg <= reg_wdata;
      end else begin
        buffer_control_reg <= reg_wdata;
      end
    end
  end

  // Controls that leave the bank come straight from register bits
  assign self_check_en = output_format_control_reg[`SELF_CHECK_BIT];
  assign low_power_en  = rate_power_control_reg[`LOW_POWER_BIT];
  assign measure_en    = power_saving_control_reg[`MEASURE_BIT];
  assign data_rate     = rate_power_control_reg[`RATE_MSB:0];

  // Feed the composer
  assign sif.raw_x      = sample_x;
  assign sif.raw_y      = sample_y;
  assign sif.raw_z      = sample_z;
  assign sif.raw_valid  = sample_valid;
  assign sif.ofs_x      = x_offset_trim_reg;
  assign sif.ofs_y      = y_offset_trim_reg;
  assign sif.ofs_z      = z_offset_trim_reg;
  assign sif.self_check = output_format_control_reg[`SELF_CHECK_BIT];
  assign sif.range_sel  =
    range_type'(output_format_control_reg[`RANGE_MSB:0]);

  axis_composer #(
    .DEFL_X (DEFL_X),
    .DEFL_Z (DEFL_Z)
  ) u_composer (
    .clk (clk),
    .rst (rst),
    .sif (sif)
  );

  // Output sample bytes; only a new sample changes them
  always_ff @(posedge clk) begin
    if (rst) begin
      x_out_reg <= 16'sh0000;
      y_out_reg <= 16'sh0000;
      z_out_reg <= 16'sh0000;
    end else if (sif.out_valid) begin
      x_out_reg <= sif.out_x;
      y_out_reg <= sif.out_y;
      z_out_reg <= sif.out_z;
    end
  end

  // New-data flag: set by a sample, cleared by reading an output byte
  always_ff @(posedge clk) begin
    if (rst) begin
      data_ready_reg <= 1'b0;
    end else if (sif.out_valid) begin
      data_ready_reg <= 1'b1;
    end else if (reg_rd && is_output(reg_addr)) begin
      data_ready_reg <= 1'b0;
    end
  end

  // Read data selection; reserved addresses read as zero
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == `ADDR_DEVICE_IDENTITY) begin
      rdata_next = DEVICE_CODE;
    end else if (reg_addr == `ADDR_X_OFFSET_TRIM) begin
      rdata_next = x_offset_trim_reg;
    end else if (reg_addr == `ADDR_Y_OFFSET_TRIM) begin
      rdata_next = y_offset_trim_reg;
    end else if (reg_addr == `ADDR_Z_OFFSET_TRIM) begin
      rdata_next = z_offset_trim_reg;
    end else if (reg_addr == `ADDR_MOTION_THRESHOLD) begin
      rdata_next = motion_threshold_reg;
    end else if (reg_addr == `ADDR_STILL_THRESHOLD) begin
      rdata_next = stillness_threshold_reg;
    end else if (reg_addr == `ADDR_STILL_TIME) begin
      rdata_next = stillness_time_reg;
    end else if (reg_addr == `ADDR_MOTION_AXIS_CTL) begin
      rdata_next = motion_axis_control_reg;
    end else if (reg_addr == `ADDR_RATE_POWER_SAVING_CONTROL) begin
      rdata_next = rate_power_control_reg;
    end else if (reg_addr == `ADDR_POWER_SAVING_CTL) begin
      rdata_next = power_saving_control_reg;
    end else if (reg_addr == `ADDR_EVENT_ENABLE) begin
      rdata_next = event_enable_reg;
    end else if (reg_addr == `ADDR_EVENT_PIN_ROUTE) begin
      rdata_next = event_pin_routing_reg;
    end else if (reg_addr == `ADDR_EVENT_ORIGIN) begin
      rdata_next = `RST_EVENT_ORIGIN | {data_ready_reg, 7'h00};
    end else if (reg_addr == `ADDR_OUTPUT_FORMAT) begin
      rdata_next = output_format_control_reg;
    end else if (reg_addr == `ADDR_X_OUTPUT_LOW) begin
      rdata_next = x_out_reg[7:0];
    end else if (reg_addr == `ADDR_X_OUTPUT_HIGH) begin
      rdata_next = x_out_reg[15:8];
    end else if (reg_addr == `ADDR_Y_OUTPUT_LOW) begin
      rdata_next = y_out_reg[7:0];
    end else if (reg_addr == `ADDR_Y_OUTPUT_HIGH) begin
      rdata_next = y_out_reg[15:8];
    end else if (reg_addr == `ADDR_Z_OUTPUT_LOW) begin
      rdata_next = z_out_reg[7:0];
    end else if (reg_addr == `ADDR_Z_OUTPUT_HIGH) begin
      rdata_next = z_out_reg[15:8];
    end else if (reg_addr == `ADDR_BUFFER_CONTROL) begin
      rdata_next = buffer_control_reg;
    end
  end

  // Read answer one cycle after the strobe; data holds until next read
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  property p_identity_fixed;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `ADDR_DEVICE_IDENTITY |=>
        reg_rvalid && reg_rdata == DEVICE_CODE;
  endproperty
  a_identity_fixed: assert property (p_identity_fixed)
    else $error("identity read returned wrong code");

  property p_rate_power_reset;
    @(posedge clk)
      rst |=> rate_power_control_reg == `RST_RATE_POWER && !low_power_en;
  endproperty
  a_rate_power_reset: assert property (p_rate_power_reset)
    else $error("rate and power control wrong after reset");

  property p_rate_power_rw;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `ADDR_RATE_POWER_SAVING_CONTROL ##1
        reg_rd && reg_addr == `ADDR_RATE_POWER_SAVING_CONTROL |=>
        reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rate_power_rw: assert property (p_rate_power_rw)
    else $error("rate and power control did not read back");

  property p_axis_ctl_reset;
    @(posedge clk) rst |=> motion_axis_control_reg == `RST_ZERO;
  endproperty
  a_axis_ctl_reset: assert property (p_axis_ctl_reset)
    else $error("motion axis control not zero after reset");

  property p_axis_ctl_write;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `ADDR_MOTION_AXIS_CTL |=>
        motion_axis_control_reg == $past(reg_wdata);
  endproperty
  a_axis_ctl_write: assert property (p_axis_ctl_write)
    else $error("motion axis control write lost");

  property p_self_check_bit;
    @(posedge clk) disable iff (rst)
      reg_wr && reg_addr == `ADDR_OUTPUT_FORMAT |=>
        self_check_en == $past(reg_wdata[`SELF_CHECK_BIT]) &&
        sif.self_check == self_check_en;
  endproperty
  a_self_check_bit: assert property (p_self_check_bit)
    else $error("self-check enable does not follow its bit");

  property p_ro_write_ignored;
    @(posedge clk) disable iff (rst)
      reg_wr && !is_writable(reg_addr) && !sif.out_valid |=>
        $stable(x_out_reg) && $stable(y_out_reg) && $stable(z_out_reg);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)
    else $error("write to read-only address changed output data");

  property p_byte_order;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `ADDR_X_OUTPUT_HIGH && !sif.out_valid |=>
        reg_rdata == x_out_reg[15:8];
  endproperty
  a_byte_order: assert property (p_byte_order)
    else $error("x high byte read wrong");

  // Low byte of an axis sits at the lower address
  property p_low_byte_first;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `ADDR_X_OUTPUT_LOW && !sif.out_valid |=>
        reg_rdata == x_out_reg[7:0];
  endproperty
  a_low_byte_first: assert property (p_low_byte_first)
    else $error("x low byte read wrong");

  // A write to a read-only place leaves the configuration alone
  property p_ro_config_kept;
    @(posedge clk) disable iff (rst)
      reg_wr && !is_writable(reg_addr) |=>
        $stable(output_format_control_reg) &&
        $stable(rate_power_control_reg) && $stable(motion_axis_control_reg);
  endproperty
  a_ro_config_kept: assert property (p_ro_config_kept)
    else $error("write to read-only address changed configuration");

endmodule // accel_register_bank

/* accel_register_map_selftest_tb_top.sv */
// Self-checking bench of the acceleration sensor register bank.
// Assumes the bank holds the output composer and answers reads a cycle late.
`timescale 1ns/100ps
`include "accel_regs.svh"
module accel_register_map_selftest_tb_top
  import accel_pkg::*;
;
  localparam byte_type   CODE = 8'h5A; // Arbitrary identification value
  localparam sample_type DX   = 16'sh012C;
  localparam sample_type DZ   = 16'sh01F4;
  typedef struct packed {
    byte_type addr;
    byte_type data;
  } expect_type;
  logic        clk;
  logic        rst;
  byte_type    reg_addr;
  byte_type    reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  byte_type    reg_rdata;
  logic        reg_rvalid;
  sample_type  sample_x;
  sample_type  sample_y;
  sample_type  sample_z;
  logic        sample_valid;
  logic        self_check_en;
  logic        low_power_en;
  logic        measure_en;
  logic [3:0]  data_rate;
  expect_type  exp_q[$];
  int          err_total;
  int          samples_checked;
  int          cycle_count;
  logic [15:0] seed;
  byte_type    vals [13];
  byte_type    trim [3];
  byte_type    rw_addr [13] = '{8'h1E, 8'h1F, 8'h20, 8'h24, 8'h25, 8'h26,
                                8'h27, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h31, 8'h38};
  byte_type    ro_addr [9] = '{8'h00, 8'h30, 8'h32, 8'h33, 8'h34, 8'h35,
                               8'h36, 8'h37, 8'h39};

  accel_register_bank #(.DEVICE_CODE(CODE), .DEFL_X(DX), .DEFL_Z(DZ)) DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z), .sample_valid(sample_valid),
    .self_check_en(self_check_en), .low_power_en(low_power_en),
    .measure_en(measure_en), .data_rate(data_rate));

  sensor_source src (.clk(clk), .sample_x(sample_x), .sample_y(sample_y),
    .sample_z(sample_z), .sample_valid(sample_valid));

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  // Cuts a hang short
  always @(posedge clk) begin
    cycle_count++;
    if (cycle_count == 20000) begin
      err_total++;
      final_report();
    end
  end

  // Takes the oldest noted read off the queue as each answer lands
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("MISMATCH rvalid expected 0 seen 1");
      end else begin
        check_byte(exp_q[0].addr, exp_q[0].data, reg_rdata);
        void'(exp_q.pop_front());
      end
    end
  end

  task automatic check_byte(input byte_type a, exp, seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH reg %h expected %h seen %h", a, exp, seen);
    end
  endtask

  task automatic check_ctl(input string what, input logic [3:0] exp, seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction

  // Expected axis value: raw plus trim times four plus scaled deflection
  function automatic sample_type axis(input sample_type raw, defl,
      input byte_type t, input logic sc, input logic [1:0] rng);
    sample_type d;
    d = sc ? (defl >>> rng) : 16'sh0000;
    return raw + (sample_type'(signed'(t)) <<< 2) + d;
  endfunction

  task automatic bus(input logic r, w, input byte_type a, d);
    reg_rd    = r;
    reg_wr    = w;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input byte_type a, d);
    bus(1'b0, 1'b1, a, d);
  endtask

  task automatic rd(input byte_type a, e);
    exp_q.push_back({a, e});
    bus(1'b1, 1'b0, a, 8'h00);
  endtask

  task automatic idle(input int n);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic end_test(input string name);
    idle(3);
    $display("test %s done", name);
  endtask

  function automatic byte_type ro_val(input byte_type a);
    return (a == 8'h00) ? CODE : ((a == 8'h30) ? 8'h02 : 8'h00);
  endfunction

  // Two samples back to back; the later one must reach the output bytes
  task automatic sample_check(input logic sc, input logic [1:0] rng);
    sample_type rx, ry, rz, ex, ey, ez;
    rx = $signed(xs()) >>> 4;
    ry = $signed(xs()) >>> 4;
    rz = $signed(xs()) >>> 4;
    ex = axis(rx, DX, trim[0], sc, rng);
    ey = axis(ry, -DX, trim[1], sc, rng);
    ez = axis(rz, DZ, trim[2], sc, rng);
    src.send(~rx, ~ry, ~rz);
    src.send(rx, ry, rz);
    src.idle();
    idle(2);
    rd(8'h30, 8'h82);
    rd(8'h32, ex[7:0]);
    rd(8'h33, ex[15:8]);
    rd(8'h34, ey[7:0]);
    rd(8'h35, ey[15:8]);
    rd(8'h36, ez[7:0]);
    rd(8'h37, ez[15:8]);
    rd(8'h30, 8'h02);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    seed = 16'hFFFD;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    // Reset values, including a read of the unmapped place 0x3A
    foreach (rw_addr[i])
      rd(rw_addr[i], rw_addr[i] == 8'h2C ? 8'h0A : 8'h00);
    foreach (ro_addr[i]) rd(ro_addr[i], ro_val(ro_addr[i]));
    rd(8'h3A, 8'h00);
    check_ctl("data_rate", 4'hA, data_rate);
    check_ctl("low_power", 4'h0, {3'h0, low_power_en});
    check_ctl("self_check", 4'h0, {3'h0, self_check_en});
    end_test("reset");
    // Random values written and read back to back
    foreach (rw_addr[i])
      vals[i] = byte_type'(xs()) & (rw_addr[i] == 8'h2C ? 8'h1F : 8'hFF);
    foreach (rw_addr[i]) wr(rw_addr[i], vals[i]);
    foreach (rw_addr[i]) rd(rw_addr[i], vals[i]);
    idle(1);
    check_ctl("data_rate", vals[7][3:0], data_rate);
    check_ctl("low_power", {3'h0, vals[7][4]}, {3'h0, low_power_en});
    check_ctl("measure", {3'h0, vals[8][3]}, {3'h0, measure_en});
    check_ctl("self_check", {3'h0, vals[11][7]}, {3'h0, self_check_en});
    end_test("read_write");
    // Writes to read-only places leave them unchanged
    foreach (ro_addr[i]) wr(ro_addr[i], ~ro_val(ro_addr[i]));
    foreach (ro_addr[i]) rd(ro_addr[i], ro_val(ro_addr[i]));
    end_test("read_only");
    // Normal power at 100 Hz, measuring, random trims
    wr(8'h2C, 8'h0A);
    rd(8'h2C, 8'h0A);
    wr(8'h2D, 8'h08);
    foreach (trim[i]) trim[i] = byte_type'(xs());
    foreach (trim[i]) wr(8'h1E + 8'(i), trim[i]);
    wr(8'h31, 8'h00);
    idle(1);
    sample_check(1'b0, 2'h0);
    for (int r = 0; r < 3; r++) begin
      wr(8'h31, {1'b1, 5'h00, 2'(r)});
      idle(1);
      check_ctl("self_check", 4'h1, {3'h0, self_check_en});
      sample_check(1'b1, 2'(r));
    end
    wr(8'h31, 8'h00);
    idle(1);
    check_ctl("self_check", 4'h0, {3'h0, self_check_en});
    sample_check(1'b0, 2'h0);
    end_test("self_check");
    if (exp_q.size() != 0) begin
      err_total++;
      $display("MISMATCH reads expected 0 left seen %0d", exp_q.size());
    end
    final_report();
  end
endmodule // accel_register_map_selftest_tb_top

/* accel_regs.svh */
// Register offsets, field positions, reset values and limits of the
// acceleration sensor register bank; included by the bank, the composer and the bench.
// Overview of operation
// - Self-check turns on and off with one bit of output format control.
// - Self-check adds a deflection that moves x, y and z outputs.
// - Lowest range: x rises 65..725, y falls, z rises 100..1175 LSB.
// - Identity register is read-only and always returns its fixed code.
// - Rate and power control resets to 00001010 and is read/write.
// - Motion axis control is read/write and resets to zero.
`ifndef ACCEL_REGS_SVH
`define ACCEL_REGS_SVH

`define ADDR_DEVICE_IDENTITY  8'h00
`define ADDR_X_OFFSET_TRIM    8'h1E
`define ADDR_Y_OFFSET_TRIM    8'h1F
`define ADDR_Z_OFFSET_TRIM    8'h20
`define ADDR_MOTION_THRESHOLD 8'h24
`define ADDR_STILL_THRESHOLD  8'h25
`define ADDR_STILL_TIME       8'h26
`define ADDR_MOTION_AXIS_CTL  8'h27
`define ADDR_RATE_POWER_SAVING_CONTROL   8'h2C
`define ADDR_POWER_SAVING_CTL 8'h2D
`define ADDR_EVENT_ENABLE     8'h2E
`define ADDR_EVENT_PIN_ROUTE  8'h2F
`define ADDR_EVENT_ORIGIN     8'h30
`define ADDR_OUTPUT_FORMAT    8'h31
`define ADDR_X_OUTPUT_LOW     8'h32
`define ADDR_X_OUTPUT_HIGH    8'h33
`define ADDR_Y_OUTPUT_LOW     8'h34
`define ADDR_Y_OUTPUT_HIGH    8'h35
`define ADDR_Z_OUTPUT_LOW     8'h36
`define ADDR_Z_OUTPUT_HIGH    8'h37
`define ADDR_BUFFER_CONTROL   8'h38
`define ADDR_BUFFER_STATE     8'h39

`define RST_ZERO              8'h00
`define RST_RATE_POWER        8'h0A
`define RST_EVENT_ORIGIN      8'h02

`define SELF_CHECK_BIT        7
`define LOW_POWER_BIT         4
`define MEASURE_BIT           3
`define DATA_READY_BIT        7
`define RATE_MSB              3
`define RANGE_MSB             1

`define LIM_X_MIN             16'sh0041
`define LIM_X_MAX             16'sh02D5
`define LIM_Z_MIN             16'sh0064
`define LIM_Z_MAX             16'sh0497

`endif

/* axis_composer.sv */
// Builds output samples: raw value plus offset trim plus self-check force.
// Assumes raw samples arrive as one-cycle pulses on the bank clock.
`timescale 1ns/100ps
`include "accel_regs.svh"
module axis_composer
  import accel_pkg::*;
#(
  parameter sample_type DEFL_X = 16'sh012C,
  parameter sample_type DEFL_Z = 16'sh01F4
) (
  input  wire logic clk,
  input  wire logic rst,
  sample_if.composer sif
);

  // Trim is 4 output LSB per trim LSB, sign extended
  function automatic sample_type trim(input byte_type t);
    return {{6{t[7]}}, t, 2'h0};
  endfunction

  // Deflection halves with each range step
  function automatic sample_type defl(input sample_type b, input range_type r);
    return b >>> r;
  endfunction

  sample_type dx;
  sample_type dy;
  sample_type dz;

  // Force added only while self-check is on
  always_comb begin
    dx = sif.self_check ? defl(DEFL_X, sif.range_sel) : 16'sh0000;
    dy = sif.self_check ? -defl(DEFL_X, sif.range_sel) : 16'sh0000;
    dz = sif.self_check ? defl(DEFL_Z, sif.range_sel) : 16'sh0000;
  end

  // Register the composed sample
  always_ff @(posedge clk) begin
    if (rst) begin
      sif.out_x     <= 16'sh0000;
      sif.out_y     <= 16'sh0000;
      sif.out_z     <= 16'sh0000;
      sif.out_valid <= 1'b0;
    end else begin
      sif.out_valid <= sif.raw_valid;
      if (sif.raw_valid) begin
        sif.out_x <= sif.raw_x + trim(sif.ofs_x) + dx;
        sif.out_y <= sif.raw_y + trim(sif.ofs_y) + dy;
        sif.out_z <= sif.raw_z + trim(sif.ofs_z) + dz;
      end
    end
  end

  // Helper: undeflected values and self-check state of the last sample
  sample_type bx;
  sample_type by;
  sample_type bz;
  logic       st_low;
  logic       st_on;
  always_ff @(posedge clk) begin
    if (rst) begin
      bx     <= 16'sh0000;
      by     <= 16'sh0000;
      bz     <= 16'sh0000;
      st_low <= 1'b0;
      st_on  <= 1'b0;
    end else if (sif.raw_valid) begin
      bx     <= sif.raw_x + trim(sif.ofs_x);
      by     <= sif.raw_y + trim(sif.ofs_y);
      bz     <= sif.raw_z + trim(sif.ofs_z);
      st_low <= sif.self_check && (sif.range_sel == RANGE_LOWEST);
      st_on  <= sif.self_check;
    end
  end

  property p_deflect_moves;
    @(posedge clk) disable iff (rst)
      sif.out_valid && st_on |->
        (sif.out_x != bx) && (sif.out_y != by) && (sif.out_z != bz);
  endproperty
  a_deflect_moves: assert property (p_deflect_moves)
    else $error("self-check did not move every axis");

  property p_lowest_limits;
    @(posedge clk) disable iff (rst)
      sif.out_valid && st_low |->
        (sif.out_x - bx >= `LIM_X_MIN) && (sif.out_x - bx <= `LIM_X_MAX) &&
        (by - sif.out_y >= `LIM_X_MIN) && (by - sif.out_y <= `LIM_X_MAX) &&
        (sif.out_z - bz >= `LIM_Z_MIN) && (sif.out_z - bz <= `LIM_Z_MAX);
  endproperty
  a_lowest_limits: assert property (p_lowest_limits)
    else $error("self-check change outside lowest-range limits");

endmodule // axis_composer

/* sample_if.sv */
// Carrier between the register bank and the output composer.
// Both ends run on the same clock.
`timescale 1ns/100ps
interface sample_if;
  import accel_pkg::*;
  sample_type raw_x;
  sample_type raw_y;
  sample_type raw_z;
  logic       raw_valid;
  byte_type   ofs_x;
  byte_type   ofs_y;
  byte_type   ofs_z;
  logic       self_check;
  range_type  range_sel;
  sample_type out_x;
  sample_type out_y;
  sample_type out_z;
  logic       out_valid;
  modport bank (output raw_x, raw_y, raw_z, raw_valid, ofs_x, ofs_y, ofs_z,
                output self_check, range_sel,
                input out_x, out_y, out_z, out_valid);
  modport composer (input raw_x, raw_y, raw_z, raw_valid, ofs_x, ofs_y,
                    input ofs_z, self_check, range_sel,
                    output out_x, out_y, out_z, out_valid);
endinterface

/* sensor_source.sv */
// Behavioural model of the sensing element that feeds raw samples.
// Assumes the bank clock; samples are launched just after a rising edge.
`timescale 1ns/100ps
module sensor_source
  import accel_pkg::*;
(
  input  wire logic clk,
  output sample_type sample_x,
  output sample_type sample_y,
  output sample_type sample_z,
  output logic       sample_valid
);
  // Lines start quiet
  initial begin
    sample_x     = 16'h0000;
    sample_y     = 16'h0000;
    sample_z     = 16'h0000;
    sample_valid = 1'b0;
  end

  // Presents one sample for the coming edge; calls may run back to back
  task automatic send(input sample_type x, y, z);
    sample_x     = x;
    sample_y     = y;
    sample_z     = z;
    sample_valid = 1'b1;
    @(posedge clk);
    #1;
  endtask

  // Ends a run of samples; idle lines show the inverse, not a held value
  task automatic idle();
    sample_valid = 1'b0;
    sample_x     = ~sample_x;
    sample_y     = ~sample_y;
    sample_z     = ~sample_z;
  endtask
endmodule // sensor_source
